// file: include/asp_pkg.sv
// Shared constants and types for the audio serial packetizer.
// Assumes a single APB clock domain (pclk) for the bus, the queue and the packetizer.
package asp_pkg;

  // Audio queue geometry and thresholds.
  localparam int ASP_QUEUE_DEPTH       = 35;
  localparam int ASP_QUEUE_WIDTH       = 36;
  localparam int ASP_CNT_W             = 6;
  localparam logic [5:0] ASP_QUEUE_FULL_LEVEL   = 6'h22;
  localparam logic [5:0] ASP_QUEUE_AFULL_LEVEL  = 6'h20;

  // Status nibble codes carried in word bits 35:32.
  localparam logic [3:0] ASP_VALID_DATA_CODE  = 4'h0;
  localparam logic [3:0] ASP_LINE_START_CODE  = 4'h1;
  localparam logic [3:0] ASP_LINE_END4_CODE   = 4'h2;
  localparam logic [3:0] ASP_LINE_END3_CODE   = 4'h3;
  localparam logic [3:0] ASP_LINE_END2_CODE   = 4'h4;
  localparam logic [3:0] ASP_LINE_END1_CODE   = 4'h5;
  localparam logic [3:0] ASP_FIELD_START_CODE = 4'h6;
  localparam logic [3:0] ASP_FIELD_END_CODE   = 4'hC;

  // APB register byte offsets.
  localparam logic [7:0] ASP_CTRL_OFS   = 8'h00;
  localparam logic [7:0] ASP_LENGTH_OFS = 8'h04;
  localparam logic [7:0] ASP_STATUS_OFS = 8'h08;

  // Control register field positions.
  localparam int ASP_CTRL_CAPTURE  = 0;
  localparam int ASP_CTRL_QUEUE_EN = 1;
  localparam int ASP_CTRL_PACKET   = 2;
  localparam int ASP_CTRL_EDGE     = 3;
  localparam int ASP_CTRL_FRAME    = 4;
  localparam int ASP_CTRL_ORDER    = 5;
  localparam int ASP_CTRL_BYTE     = 6;
  localparam int ASP_CTRL_LIMIT    = 7;
  localparam int ASP_CTRL_DELAY    = 8;
  localparam int ASP_DELAY_W       = 5;

  // Length register field positions and widths.
  localparam int ASP_LEN_W         = 12;
  localparam int ASP_LEN_LINE      = 0;
  localparam int ASP_LEN_FIELD     = 16;
  localparam logic [11:0] ASP_LINE_RESET  = 12'h010;
  localparam logic [11:0] ASP_FIELD_RESET = 12'h004;

  // Status register field positions.
  localparam int ASP_STAT_COUNT    = 0;
  localparam int ASP_STAT_FULL     = 8;
  localparam int ASP_STAT_AFULL    = 9;
  localparam int ASP_STAT_OVERFLOW = 10;
  localparam int ASP_STAT_BUSY     = 11;

  // Serial word sizes in bits.
  localparam logic [4:0] ASP_SAMPLE_BITS = 5'h10;
  localparam logic [4:0] ASP_BYTE_BITS   = 5'h08;

  // Dropout marker values and their replacements.
  localparam logic [15:0] ASP_MARK16 = 16'h8000;
  localparam logic [15:0] ASP_SUBST16 = 16'h8001;
  localparam logic [7:0]  ASP_MARK8  = 8'h80;
  localparam logic [7:0]  ASP_SUBST8 = 8'h81;

  // Capture sequence states.
  typedef enum logic [1:0] {
    ASP_ST_IDLE   = 2'b00,
    ASP_ST_FSTART = 2'b01,
    ASP_ST_LINES  = 2'b10,
    ASP_ST_FEND   = 2'b11
  } asp_cap_state_t;

endpackage

// file: hw/asp_queue.sv
// Audio queue storage: flip-flop array with write and read pointers.
// Assumes the caller never pushes when full and never pops when empty;
// both sides run on pclk.
`timescale 1ns/1ps
module asp_queue
  import asp_pkg::*;
#(
  parameter int DEPTH = ASP_QUEUE_DEPTH,
  parameter int WIDTH = ASP_QUEUE_WIDTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] pop_data,
  output logic                  pop_valid
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [WIDTH-1:0]            rdata;
    logic                        rvalid;
  } asp_queue_state_t;

  asp_queue_state_t s;
  asp_queue_state_t next_s;

  // Pointer update, write into the array and registered read-out.
  always_comb begin
    next_s = s;
    next_s.rvalid = 1'b0;
    if (push) begin
      next_s.mem[s.wr_ptr] = push_data;
      next_s.wr_ptr = (s.wr_ptr == LAST) ? '0 : s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rdata = s.mem[s.rd_ptr];
      next_s.rvalid = 1'b1;
      next_s.rd_ptr = (s.rd_ptr == LAST) ? '0 : s.rd_ptr + 1'b1;
    end
    if (clear) begin
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
      next_s.rvalid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pop_data  = s.rdata;
  assign pop_valid = s.rvalid;
endmodule

// file: hw/asp_audio_serial_packetizer.sv
// Audio serial packetizer: three-wire serial input, packing, status tagging and queue.
// Assumes pclk far faster than the serial bit clock, and a drain-side master on pclk
// that raises pop_req only while it wants words.
//
// Summary of operation
// - Queue holds 35 words; full 34, almost 32.
// - Never push on two consecutive cycles.
// - Six-bit occupancy counter, cleared while queue disabled.
// - First word after capture start is field-start.
// - Line over four bytes is start, valid words, then line-end; else one line-end word.
// - Lines start aligned; short last word right-justified.
// - Field-end word after field-length lines.
// - Capture bit clear stops capture only after field-end word queued.
// - Queue disable stops capture at once, restarts field.
// - Little-endian packing, status in top nibble.
// - Mode bit selects stereo or byte packets.
// - Bit clock resampled; sync and data sampled on it.
// - Edge bit selects rising or falling sampling.
// - Frame-edge bit selects rising or falling sync as packet start.
// - Delay field sets first-bit offset after sync.
// - Order bit selects MSB-first or LSB-first.
// - Surplus stereo bit clocks are ignored.
// - Packet bytes every eight clocks after delay.
// - Packet mode forwards line-length bytes per frame.
// - Limit bit replaces dropout marker samples.
// - Both queue sides run on the bus clock.
`timescale 1ns/1ps
module asp_audio_serial_packetizer
  import asp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_bit_clock,
  input  wire logic        frame_sync_in,
  input  wire logic        serial_data_in,
  input  wire logic        pop_req,
  output logic      [35:0] pop_data,
  output logic             pop_valid
);
  typedef struct packed {
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   capture_enable;
    logic                   queue_enable;
    logic                   packet_mode_select;
    logic                   sample_edge_select;
    logic                   frame_edge_select;
    logic                   bit_order_select;
    logic                   byte_sample_select;
    logic                   dropout_code_limit;
    logic [ASP_DELAY_W-1:0] frame_bit_delay;
    logic [ASP_LEN_W-1:0]   line_packet_bytes;
    logic [ASP_LEN_W-1:0]   field_packet_lines;
    logic                   overflow;
    logic [2:0]             sclk_sync;
    logic [1:0]             lr_sync;
    logic [1:0]             dat_sync;
    logic                   lr_last;
    logic [ASP_DELAY_W-1:0] skip;
    logic [4:0]             bits;
    logic                   collecting;
    logic                   low_half;
    logic [ASP_LEN_W-1:0]   frame_bytes;
    logic                   first_pend;
    logic [15:0]            shreg;
    logic [15:0]            half_lo;
    logic                   lo_valid;
    asp_cap_state_t         state;
    logic [31:0]            acc;
    logic [2:0]             acc_n;
    logic [ASP_LEN_W-1:0]   line_left;
    logic [ASP_LEN_W-1:0]   lines_left;
    logic                   line_first;
    logic                   pend;
    logic [35:0]            pend_word;
    logic                   push;
    logic [35:0]            push_word;
    logic [ASP_CNT_W-1:0]   cnt;
  } asp_state_t;

  asp_state_t s;
  asp_state_t next_s;

  logic                   tick;
  logic                   lr_rise;
  logic                   lr_fall;
  logic                   sync_edge;
  logic [ASP_DELAY_W-1:0] skip_eff;
  logic [4:0]             bits_eff;
  logic                   coll_eff;
  logic [15:0]            sh_next;
  logic [7:0]             byte_in;
  logic [15:0]            sample;
  logic                   in_valid;
  logic                   in_first;
  logic [2:0]             in_n;
  logic [31:0]            in_data;
  logic [2:0]             take;
  logic [2:0]             fill;
  logic [2:0]             lane;
  logic [ASP_LEN_W-1:0]   left;
  logic [3:0]             end_code;
  logic                   pop_ok;
  logic                   access;
  logic [31:0]            rd_value;
  logic                   rd_hit;

  // Dropout marker replacement for a 16-bit sample.
  function automatic logic [15:0] fix16(input logic lim, input logic [15:0] v);
    fix16 = (lim && v == ASP_MARK16) ? ASP_SUBST16 : v;
  endfunction

  // Dropout marker replacement for a byte.
  function automatic logic [7:0] fix8(input logic lim, input logic [7:0] v);
    fix8 = (lim && v == ASP_MARK8) ? ASP_SUBST8 : v;
  endfunction

  // Serial front end: resampling, sync detection, bit assembly.
  always_comb begin
    next_s = s;
    in_valid = 1'b0;
    in_first = 1'b0;
    in_n = 3'h0;
    in_data = 32'h0;
    skip_eff = s.skip;
    bits_eff = s.bits;
    coll_eff = s.collecting;
    sh_next = s.shreg;
    byte_in = 8'h00;
    sample = 16'h0000;
    next_s.sclk_sync = {s.sclk_sync[1:0], serial_bit_clock};
    next_s.lr_sync = {s.lr_sync[0], frame_sync_in};
    next_s.dat_sync = {s.dat_sync[0], serial_data_in};
    tick = s.sample_edge_select ? (s.sclk_sync[2] & ~s.sclk_sync[1])
                                : (s.sclk_sync[1] & ~s.sclk_sync[2]);
    lr_rise = s.lr_sync[1] & ~s.lr_last;
    lr_fall = ~s.lr_sync[1] & s.lr_last;
    sync_edge = s.packet_mode_select ? (s.frame_edge_select ? lr_fall : lr_rise)
                                     : (lr_rise | lr_fall);
    if (tick) begin
      next_s.lr_last = s.lr_sync[1];
      if (sync_edge) begin
        skip_eff = s.frame_bit_delay;
        bits_eff = 5'h00;
        coll_eff = 1'b1;
        next_s.low_half = s.lr_sync[1];
        next_s.frame_bytes = s.line_packet_bytes;
        next_s.first_pend = 1'b1;
      end
      next_s.collecting = coll_eff;
      next_s.bits = bits_eff;
      next_s.skip = skip_eff;
      if (coll_eff && skip_eff != '0) begin
        next_s.skip = skip_eff - 1'b1;
      end else if (coll_eff) begin
        sh_next = s.bit_order_select ? {s.dat_sync[1], s.shreg[15:1]}
                                     : {s.shreg[14:0], s.dat_sync[1]};
        next_s.shreg = sh_next;
        next_s.bits = bits_eff + 1'b1;
        if (bits_eff + 1'b1 == (s.packet_mode_select ? ASP_BYTE_BITS : ASP_SAMPLE_BITS)) begin
          next_s.bits = 5'h00;
          if (s.packet_mode_select) begin
            byte_in = s.bit_order_select ? sh_next[15:8] : sh_next[7:0];
            in_valid = s.frame_bytes != '0;
            in_first = s.first_pend;
            in_n = 3'h1;
            in_data = {24'h000000, fix8(s.dropout_code_limit, byte_in)};
            next_s.first_pend = 1'b0;
            next_s.frame_bytes = (s.frame_bytes != '0) ? s.frame_bytes - 1'b1 : '0;
            next_s.collecting = s.frame_bytes > 12'h001;
          end else begin
            next_s.collecting = 1'b0;
            sample = s.byte_sample_select
                     ? {fix8(s.dropout_code_limit, sh_next[15:8]),
                        fix8(s.dropout_code_limit, sh_next[7:0])}
                     : fix16(s.dropout_code_limit, sh_next);
            if (s.low_half) begin
              next_s.half_lo = sample;
              next_s.lo_valid = 1'b1;
            end else if (s.lo_valid) begin
              in_valid = 1'b1;
              in_n = 3'h4;
              in_data = {sample, s.half_lo};
              next_s.lo_valid = 1'b0;
            end
          end
        end
      end
    end

    // Write one clears overflow first, so a drop below in the same cycle wins.
    if (psel && penable && s.pready && pwrite && paddr == ASP_STATUS_OFS
        && pwdata[ASP_STAT_OVERFLOW]) begin
      next_s.overflow = 1'b0;
    end

    next_s.push = 1'b0;
    if (s.pend && !s.push) begin
      next_s.pend = 1'b0;
      if (s.cnt < ASP_QUEUE_FULL_LEVEL) begin
        next_s.push = 1'b1;
        next_s.push_word = s.pend_word;
      end else begin
        next_s.overflow = 1'b1;
      end
    end

    // Capture sequence and DWORD packing.
    take = 3'h0;
    fill = 3'h0;
    lane = 3'h0;
    left = s.line_left;
    end_code = ASP_LINE_END4_CODE;
    case (s.state)
      ASP_ST_IDLE: begin
        if (s.capture_enable && s.queue_enable) begin
          next_s.state = ASP_ST_FSTART;
        end
      end
      ASP_ST_FSTART: begin
        if (!next_s.pend) begin
          next_s.pend = 1'b1;
          next_s.pend_word = {ASP_FIELD_START_CODE, 32'h00000000};
          next_s.line_left = s.line_packet_bytes;
          next_s.lines_left = s.field_packet_lines;
          next_s.acc = 32'h0;
          next_s.acc_n = 3'h0;
          next_s.line_first = 1'b1;
          next_s.lo_valid = 1'b0;
          next_s.state = ASP_ST_LINES;
        end
      end
      ASP_ST_LINES: begin
        if (in_valid && !(s.packet_mode_select && s.line_first && s.acc_n == 3'h0
                          && !in_first)) begin
          take = (12'(in_n) > s.line_left) ? s.line_left[2:0] : in_n;
          if (take > 3'h4 - s.acc_n) begin
            take = 3'h4 - s.acc_n;
          end
          next_s.acc = s.acc;
          for (int i = 0; i < 4; i++) begin
            lane = s.acc_n + 3'(i);
            if (3'(i) < take && lane < 3'h4) begin
              next_s.acc[lane[1:0]*8 +: 8] = in_data[i*8 +: 8];
            end
          end
          fill = s.acc_n + take;
          left = s.line_left - 12'(take);
          next_s.acc_n = fill;
          next_s.line_left = left;
          if (fill == 3'h4 || left == '0) begin
            case (fill)
              3'h1: end_code = ASP_LINE_END1_CODE;
              3'h2: end_code = ASP_LINE_END2_CODE;
              3'h3: end_code = ASP_LINE_END3_CODE;
              default: end_code = ASP_LINE_END4_CODE;
            endcase
            if (next_s.pend) begin
              next_s.overflow = 1'b1;
            end
            next_s.pend = 1'b1;
            next_s.pend_word = {(left == '0) ? end_code
                                : (s.line_first ? ASP_LINE_START_CODE : ASP_VALID_DATA_CODE),
                                next_s.acc};
            next_s.acc = 32'h0;
            next_s.acc_n = 3'h0;
            next_s.line_first = 1'b0;
            if (left == '0) begin
              next_s.line_left = s.line_packet_bytes;
              next_s.line_first = 1'b1;
              next_s.lines_left = s.lines_left - 1'b1;
              if (s.lines_left <= 12'h001) begin
                next_s.state = ASP_ST_FEND;
              end
            end
          end
        end
      end
      ASP_ST_FEND: begin
        if (!next_s.pend) begin
          next_s.pend = 1'b1;
          next_s.pend_word = {ASP_FIELD_END_CODE, 32'h00000000};
          next_s.state = s.capture_enable ? ASP_ST_FSTART : ASP_ST_IDLE;
        end
      end
      default: next_s.state = ASP_ST_IDLE;
    endcase

    pop_ok = pop_req && s.queue_enable && s.cnt != '0;
    next_s.cnt = s.cnt + ASP_CNT_W'(s.push) - ASP_CNT_W'(pop_ok);

    if (!s.queue_enable) begin
      next_s.cnt = '0;
      next_s.state = ASP_ST_IDLE;
      next_s.pend = 1'b0;
      next_s.push = 1'b0;
      next_s.acc = 32'h0;
      next_s.acc_n = 3'h0;
    end

    // APB slave with one wait state; write and read happen on the pready edge.
    access = psel && penable;
    next_s.pready = access && !s.pready;
    rd_value = 32'h0;
    rd_hit = 1'b1;
    if (paddr == ASP_CTRL_OFS) begin
      rd_value[ASP_CTRL_CAPTURE] = s.capture_enable;
      rd_value[ASP_CTRL_QUEUE_EN] = s.queue_enable;
      rd_value[ASP_CTRL_PACKET] = s.packet_mode_select;
      rd_value[ASP_CTRL_EDGE] = s.sample_edge_select;
      rd_value[ASP_CTRL_FRAME] = s.frame_edge_select;
      rd_value[ASP_CTRL_ORDER] = s.bit_order_select;
      rd_value[ASP_CTRL_BYTE] = s.byte_sample_select;
      rd_value[ASP_CTRL_LIMIT] = s.dropout_code_limit;
      rd_value[ASP_CTRL_DELAY +: ASP_DELAY_W] = s.frame_bit_delay;
    end else if (paddr == ASP_LENGTH_OFS) begin
      rd_value[ASP_LEN_LINE +: ASP_LEN_W] = s.line_packet_bytes;
      rd_value[ASP_LEN_FIELD +: ASP_LEN_W] = s.field_packet_lines;
    end else if (paddr == ASP_STATUS_OFS) begin
      rd_value[ASP_STAT_COUNT +: ASP_CNT_W] = s.cnt;
      rd_value[ASP_STAT_FULL] = s.cnt >= ASP_QUEUE_FULL_LEVEL;
      rd_value[ASP_STAT_AFULL] = s.cnt >= ASP_QUEUE_AFULL_LEVEL;
      rd_value[ASP_STAT_OVERFLOW] = s.overflow;
      rd_value[ASP_STAT_BUSY] = s.state != ASP_ST_IDLE;
    end else begin
      rd_hit = 1'b0;
    end
    if (access && !s.pready) begin
      next_s.prdata = pwrite ? 32'h0 : rd_value;
      next_s.pslverr = !rd_hit;
    end else begin
      next_s.prdata = 32'h0;
      next_s.pslverr = 1'b0;
    end
    if (access && s.pready && pwrite && rd_hit) begin
      if (paddr == ASP_CTRL_OFS) begin
        next_s.capture_enable = pwdata[ASP_CTRL_CAPTURE];
        next_s.queue_enable = pwdata[ASP_CTRL_QUEUE_EN];
        next_s.packet_mode_select = pwdata[ASP_CTRL_PACKET];
        next_s.sample_edge_select = pwdata[ASP_CTRL_EDGE];
        next_s.frame_edge_select = pwdata[ASP_CTRL_FRAME];
        next_s.bit_order_select = pwdata[ASP_CTRL_ORDER];
        next_s.byte_sample_select = pwdata[ASP_CTRL_BYTE];
        next_s.dropout_code_limit = pwdata[ASP_CTRL_LIMIT];
        next_s.frame_bit_delay = pwdata[ASP_CTRL_DELAY +: ASP_DELAY_W];
      end else if (paddr == ASP_LENGTH_OFS) begin
        next_s.line_packet_bytes = pwdata[ASP_LEN_LINE +: ASP_LEN_W];
        next_s.field_packet_lines = pwdata[ASP_LEN_FIELD +: ASP_LEN_W];
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.line_packet_bytes <= ASP_LINE_RESET;
      s.field_packet_lines <= ASP_FIELD_RESET;
      s.state <= ASP_ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  asp_queue #(
    .DEPTH (ASP_QUEUE_DEPTH),
    .WIDTH (ASP_QUEUE_WIDTH)
  ) u_queue (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (!s.queue_enable),
    .push      (s.push),
    .push_data (s.push_word),
    .pop       (pop_ok),
    .pop_data  (pop_data),
    .pop_valid (pop_valid)
  );

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
endmodule

// file: tb/asp_props.sv
// Port-level checker for the audio serial packetizer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module asp_props
  import asp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_bit_clock,
  input wire logic        frame_sync_in,
  input wire logic        serial_data_in,
  input wire logic        pop_req,
  input wire logic [35:0] pop_data,
  input wire logic        pop_valid
);
  // All checks share the bus clock and its reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late after access start");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_pready_qual: assert property (pready |-> psel && penable)
    else $error("pready without a transfer");
  a_err_unmapped: assert property (pready && !(paddr inside {8'h00, 8'h04, 8'h08}) |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && (paddr inside {8'h00, 8'h04, 8'h08}) |-> !pslverr)
    else $error("error on mapped address");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_rd_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_pop_cause: assert property (pop_valid |-> $past(pop_req))
    else $error("pop_valid without request");
  a_pop_hold: assert property (!pop_valid |-> $stable(pop_data))
    else $error("pop_data moved without a pop");
endmodule

// file: tb/asp_src_model.sv
// Serial audio source model driving the three-wire input.
// Assumes rising-edge sampling, MSB first and no frame delay.
`timescale 1ns/1ps
module asp_src_model (
  output logic serial_bit_clock,
  output logic frame_sync_in,
  output logic serial_data_in
);
  // The bit clock rests low between frames.
  initial begin
    serial_bit_clock = 1'b0;
    frame_sync_in = 1'b0;
    serial_data_in = 1'b0;
  end
  // Sends one bit: data set half a period before the rising edge.
  task automatic send_bit(input logic b, input logic f);
    serial_data_in = b;
    frame_sync_in = f;
    serial_bit_clock = 1'b0;
    #400;
    serial_bit_clock = 1'b1;
    #400;
  endtask
  // sixteen bits per half, left on rising sync
  task automatic send_pair(input logic [15:0] l, input logic [15:0] r, input int extra);
    #37;
    for (int i = 15; i >= 0; i--) send_bit(l[i], 1'b1);
    for (int i = 15; i >= 0; i--) send_bit(r[i], 1'b0);
    repeat (extra) send_bit(~serial_data_in, 1'b0);
    serial_bit_clock = 1'b0;
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// file: tb/tb_audio_serial_packetizer.sv
// Testbench for the audio serial packetizer: APB master, drain side, serial source.
// Assumes the design's one-wait-state APB and one-cycle pop answer.
`timescale 1ns/1ps
module tb_audio_serial_packetizer;
  import asp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pop_req, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, pop_valid;
  logic [35:0] pop_data;
  logic        serial_bit_clock, frame_sync_in, serial_data_in;
  int          num_errors, n_tests, cyc;
  logic [40:0] rows [4] = '{{8'h00, 32'h0, 1'b0}, {8'h04, 32'h0004_0010, 1'b0},
                            {8'h08, 32'h0, 1'b0}, {8'h0C, 32'h0, 1'b1}};
  asp_audio_serial_packetizer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_bit_clock, .frame_sync_in,
    .serial_data_in, .pop_req, .pop_data, .pop_valid);
  asp_src_model src_u (.serial_bit_clock, .frame_sync_in, .serial_data_in);
  // Clock at 10 MHz.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Cuts a hung run short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // Compares the masked bits and counts the result.
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input logic [35:0] m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads a register and checks data and error flag.
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk({3'b0, er, rd}, {3'b0, ee, e}, 36'hF_FFFF_FFFF);
  endtask
  // Pops one word and checks it.
  task automatic pop_chk(input logic [35:0] e, input logic [35:0] m);
    @(posedge pclk);
    pop_req <= 1'b1;
    @(posedge pclk);
    pop_req <= 1'b0;
    @(posedge pclk);
    while (pop_valid !== 1'b1) @(posedge pclk);
    chk(pop_data, e, m);
  endtask
  // Prints the counts and the verdict.
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence: register rows, one stereo field, then queue disable.
  initial begin
    {presetn, psel, penable, pwrite, pop_req} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) rchk(rows[i][40:33], rows[i][32:1], rows[i][0]);
    apb(1'b1, ASP_LENGTH_OFS, 32'h0001_000C);
    apb(1'b1, ASP_CTRL_OFS, 32'h0000_0083);
    src_u.send_pair(16'h8000, 16'h1234, 3);
    apb(1'b1, ASP_CTRL_OFS, 32'h0000_0082);
    src_u.send_pair(16'h00AB, 16'h8000, 0);
    src_u.send_pair(16'h5A5A, 16'hC3C3, 0);
    src_u.send_pair(16'h1111, 16'h2222, 0);
    repeat (20) @(posedge pclk);
    rchk(ASP_STATUS_OFS, 32'h5, 1'b0);
    pop_chk({4'h6, 32'h0}, 36'hF_0000_0000);
    pop_chk({4'h1, 32'h1234_8001}, 36'hF_FFFF_FFFF);
    pop_chk({4'h0, 32'h8001_00AB}, 36'hF_FFFF_FFFF);
    pop_chk({4'h2, 32'hC3C3_5A5A}, 36'hF_FFFF_FFFF);
    pop_chk({4'hC, 32'h0}, 36'hF_0000_0000);
    rchk(ASP_STATUS_OFS, 32'h0, 1'b0);
    apb(1'b1, ASP_CTRL_OFS, 32'h0000_0003);
    src_u.send_pair(16'h0F0F, 16'hF0F0, 0);
    repeat (20) @(posedge pclk);
    rchk(ASP_STATUS_OFS, 32'h802, 1'b0);
    apb(1'b1, ASP_CTRL_OFS, 32'h0);
    rchk(ASP_STATUS_OFS, 32'h0, 1'b0);
    // Packet mode, LSB first: three-byte lines, field of one line, capture kept on.
    apb(1'b1, ASP_LENGTH_OFS, 32'h0001_0003);
    apb(1'b1, ASP_CTRL_OFS, 32'h0000_0027);
    src_u.send_pair(16'hA1C3, 16'h8000, 0);
    repeat (20) @(posedge pclk);
    rchk(ASP_STATUS_OFS, 32'h804, 1'b0);
    pop_chk({4'h6, 32'h0}, 36'hF_0000_0000);
    pop_chk({4'h3, 32'h0001_C385}, 36'hF_FFFF_FFFF);
    pop_chk({4'hC, 32'h0}, 36'hF_0000_0000);
    // Fill the queue past full with a long stereo line, then clear the overflow flag.
    apb(1'b1, ASP_CTRL_OFS, 32'h0);
    apb(1'b1, ASP_LENGTH_OFS, 32'h0001_00FC);
    apb(1'b1, ASP_CTRL_OFS, 32'h0000_0003);
    for (int i = 0; i < 34; i++) src_u.send_pair(16'h0, 16'h0, 0);
    repeat (20) @(posedge pclk);
    rchk(ASP_STATUS_OFS, 32'hF22, 1'b0);
    apb(1'b1, ASP_STATUS_OFS, 32'h0000_0400);
    rchk(ASP_STATUS_OFS, 32'hB22, 1'b0);
    apb(1'b1, ASP_CTRL_OFS, 32'h0);
    report_and_stop();
  end
endmodule
bind asp_audio_serial_packetizer asp_props props_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_bit_clock,
  .frame_sync_in, .serial_data_in, .pop_req, .pop_data, .pop_valid);
